// file: shared/bp_match_consts.svh
// Offsets, field positions, reset values and encodings for the breakpoint match block
`ifndef BP_MATCH_CONSTS_SVH
`define BP_MATCH_CONSTS_SVH

`define BP_COUNT          16
`define BT_HI             23
`define BT_LO             20
`define LBN_HI            19
`define LBN_LO            16
`define SSC_HI            15
`define SSC_LO            14
`define HMC_BIT           13
`define BAS_HI            8
`define BAS_LO            5
`define PMC_HI            2
`define PMC_LO            1
`define ENABLE_BIT        0
`define BCR_WRITE_MASK    32'h00ffe1e7
`define BCR_RESET         32'h00000000
`define BVR_RESET         64'h0000000000000000
`define S2TB_RESET        64'h0000000000000000
`define BAS_ALL_ONES      4'hf
`define BAS_LOW_HALF      4'h3
`define BAS_HIGH_HALF     4'hc
`define ONLY_WIDE_STATE   1'h0
`define TAG_HI            63
`define TAG_LO            48
`define BASE_HI           47
`define BVR_TAG_HI        47
`define BVR_TAG_LO        32
`define BVR_VA_HI         48
`define BVR_VA_LO         2
`define OP0_DEBUG         2'h2
`define OP0_SYSTEM        2'h3
`define OP1_DEBUG         3'h0
`define OP1_HYP           3'h4
`define CRN_DEBUG         4'h0
`define CRN_S2            4'h2
`define CRM_S2            4'h1
`define OP2_BVR           3'h4
`define OP2_BCR           3'h5
`define OP2_S2TB          3'h0
`define OP2_S2TC          3'h2
`define EL_HYP            2'h2
`define EL_SUPER          2'h1

`endif

// file: shared/bp_match_pkg.sv
// Types shared by the breakpoint control and match block
package bp_match_pkg;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  op0;
      logic [2:0]  op1;
      logic [3:0]  crn;
      logic [3:0]  crm;
      logic [2:0]  op2;
      logic [1:0]  el;
      logic [63:0] wdata;
   } sysreg_req_type;

   typedef struct packed {
      logic        valid;
      logic        undef;
      logic [63:0] rdata;
   } sysreg_rsp_type;

   typedef struct packed {
      logic        pc_valid;
      logic [48:0] pc;
      logic [1:0]  el;
      logic        secure;
      logic        host_mode;
      logic        el2_is_narrow;
      logic        tag_width_select;
      logic [5:0]  base_align_bit;
      logic [31:0] el1_context_tag_reg;
      logic [31:0] hyp_context_tag_reg;
   } pe_state_type;

endpackage : bp_match_pkg

// file: rtl/breakpoint_control_match.sv
// Breakpoint control registers, stage-2 table base register and breakpoint match logic
//
// Function
// - Control registers kept across warm reset
// - Type field bits 23:20 selects comparison
// - Base type 000 matches instruction address
// - Base type 100 compares guest tag
// - Base type 101 needs tag and context
// - Base type 110 compares hypervisor context only
// - Base type 111 compares both contexts
// - Base type 011 always uses EL1 context
// - Linked index bits 19:16 used for links
// - Linked index ignored while disabled
// - Security select bits 15:14 gate events
// - Higher level select bit 13 gates events
// - Halfword select chooses matched halfwords
// - Wide-only build reads halfword select ones
// - Context types read halfword select ones
// - Guest tag in bits 63:48, upper zero
// - Tag width select gates upper tag bits
// - Narrow hypervisor state ignores upper tag
// - Table base field bits 47:0, aligned
// - Misaligned base bits treated as zero
// - Stage-2 registers decoded by system encoding
// - Bit 0 enables the breakpoint
// - Value register meaning follows type field
`include "bp_match_consts.svh"

module breakpoint_control_match (
   input  wire logic                        i_clock,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_warm_rst_n,
   input  wire bp_match_pkg::sysreg_req_type i_sysreg_req,
   input  wire bp_match_pkg::pe_state_type  i_pe,
   output bp_match_pkg::sysreg_rsp_type     o_sysreg_rsp,
   output logic [`BP_COUNT-1:0]             o_break_hit,
   output logic                             o_debug_event,
   output logic [47:0]                      o_walk_base,
   output logic [15:0]                      o_guest_machine_tag
);

   ////////////////////////////////////////////////////////////////////////////
   // Storage

   logic [31:0] breakpoint_control_reg [`BP_COUNT];
   logic [63:0] breakpoint_value_reg   [`BP_COUNT];
   logic [63:0] stage2_table_base_reg;
   logic [31:0] stage2_translation_control_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [2:0] base_type(input logic [31:0] ctl);
      base_type = ctl[`BT_HI:`BT_LO+1];
   endfunction : base_type

   function automatic logic is_context_type(input logic [2:0] bt);
      is_context_type = (bt == 3'h1) || (bt == 3'h3) || (bt[2] == 1'h1);
   endfunction : is_context_type

   // Upper tag byte only counts with a wide tag in the wide execution state
   function automatic logic [15:0] effective_tag(input logic [15:0] tag, input logic wide_sel,
                                                 input logic el2_narrow);
      if (wide_sel && !el2_narrow) begin
         effective_tag = tag;
      end else begin
         effective_tag = {8'h00, tag[7:0]};
      end
   endfunction : effective_tag

   // Event filter on security state, level and perspective
   function automatic logic state_allows(input logic [31:0] ctl, input logic [1:0] el,
                                         input logic secure);
      logic ssc_ok;
      logic lvl_ok;
      ssc_ok = 1'h0;
      lvl_ok = 1'h0;
      unique case (ctl[`SSC_HI:`SSC_LO])
         2'h0: ssc_ok = 1'h1;
         2'h1: ssc_ok = !secure;
         2'h2: ssc_ok = secure;
         2'h3: ssc_ok = !secure;
      endcase
      unique case (el)
         2'h0: lvl_ok = ctl[`PMC_HI];
         2'h1: lvl_ok = ctl[`PMC_LO];
         2'h2: lvl_ok = ctl[`HMC_BIT];
         2'h3: lvl_ok = ctl[`HMC_BIT] && ctl[`SSC_HI] && !ctl[`SSC_LO];
      endcase
      state_allows = ssc_ok && lvl_ok;
   endfunction : state_allows

   function automatic logic [31:0] control_readback(input logic [31:0] ctl);
      logic [31:0] rd;
      rd = ctl & `BCR_WRITE_MASK;
      if (`ONLY_WIDE_STATE || is_context_type(base_type(ctl))) begin
         rd[`BAS_HI:`BAS_LO] = `BAS_ALL_ONES;
      end
      control_readback = rd;
   endfunction : control_readback

   ////////////////////////////////////////////////////////////////////////////
   // Access decode

   logic       sel_bcr;
   logic       sel_bvr;
   logic       sel_s2tb;
   logic       sel_s2tc;
   logic       level_ok;
   logic [3:0] bp_index;

   always_comb begin
      bp_index = i_sysreg_req.crm;
      sel_bcr  = (i_sysreg_req.op0 == `OP0_DEBUG) && (i_sysreg_req.op1 == `OP1_DEBUG)
              && (i_sysreg_req.crn == `CRN_DEBUG) && (i_sysreg_req.op2 == `OP2_BCR);
      sel_bvr  = (i_sysreg_req.op0 == `OP0_DEBUG) && (i_sysreg_req.op1 == `OP1_DEBUG)
              && (i_sysreg_req.crn == `CRN_DEBUG) && (i_sysreg_req.op2 == `OP2_BVR);
      sel_s2tb = (i_sysreg_req.op0 == `OP0_SYSTEM) && (i_sysreg_req.op1 == `OP1_HYP)
              && (i_sysreg_req.crn == `CRN_S2) && (i_sysreg_req.crm == `CRM_S2)
              && (i_sysreg_req.op2 == `OP2_S2TB);
      sel_s2tc = (i_sysreg_req.op0 == `OP0_SYSTEM) && (i_sysreg_req.op1 == `OP1_HYP)
              && (i_sysreg_req.crn == `CRN_S2) && (i_sysreg_req.crm == `CRM_S2)
              && (i_sysreg_req.op2 == `OP2_S2TC);
      if (sel_s2tb || sel_s2tc) begin
         level_ok = (i_sysreg_req.el >= `EL_HYP);
      end else begin
         level_ok = (i_sysreg_req.el >= `EL_SUPER);
      end
   end

   logic do_write;
   assign do_write = i_sysreg_req.valid && i_sysreg_req.write && level_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes; only the cold reset clears breakpoint state

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         for (int i = 0; i < `BP_COUNT; i++) begin
            breakpoint_control_reg[i] <= `BCR_RESET;
            breakpoint_value_reg[i]   <= `BVR_RESET;
         end
      end else if (do_write && sel_bcr) begin
         breakpoint_control_reg[bp_index] <= i_sysreg_req.wdata[31:0] & `BCR_WRITE_MASK;
      end else if (do_write && sel_bvr) begin
         breakpoint_value_reg[bp_index] <= i_sysreg_req.wdata;
      end
   end

   // Written value kept as is; alignment is applied where the base is used
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         stage2_table_base_reg <= `S2TB_RESET;
      end else if (do_write && sel_s2tb) begin
         stage2_table_base_reg <= i_sysreg_req.wdata;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         stage2_translation_control_reg <= 32'h00000000;
      end else if (do_write && sel_s2tc) begin
         stage2_translation_control_reg <= i_sysreg_req.wdata[31:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read response, one cycle after the request

   always_ff @(posedge i_clock) begin
      if (!i_rst_n || !i_warm_rst_n) begin
         o_sysreg_rsp <= '0;
      end else begin
         o_sysreg_rsp.valid <= i_sysreg_req.valid;
         o_sysreg_rsp.undef <= i_sysreg_req.valid
                            && (!(sel_bcr || sel_bvr || sel_s2tb || sel_s2tc) || !level_ok);
         o_sysreg_rsp.rdata <= 64'h0000000000000000;
         if (i_sysreg_req.valid && !i_sysreg_req.write && level_ok) begin
            if (sel_bcr) begin
               o_sysreg_rsp.rdata <= {32'h00000000, control_readback(breakpoint_control_reg[bp_index])};
            end else if (sel_bvr) begin
               o_sysreg_rsp.rdata <= breakpoint_value_reg[bp_index];
            end else if (sel_s2tb) begin
               o_sysreg_rsp.rdata <= stage2_table_base_reg;
            end else if (sel_s2tc) begin
               o_sysreg_rsp.rdata <= {32'h00000000, stage2_translation_control_reg};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Comparisons

   logic [15:0]           cur_tag;
   logic [47:0]           align_mask;
   logic [`BP_COUNT-1:0]  ctx_hit;
   logic [`BP_COUNT-1:0]  addr_hit;
   logic [`BP_COUNT-1:0]  next_hit;

   always_comb begin
      cur_tag    = effective_tag(stage2_table_base_reg[`TAG_HI:`TAG_LO], i_pe.tag_width_select,
                                 i_pe.el2_is_narrow);
      align_mask = 48'hffffffffffff << i_pe.base_align_bit;
   end

   always_comb begin
      for (int i = 0; i < `BP_COUNT; i++) begin
         logic [31:0] ctl;
         logic [63:0] val;
         logic [15:0] want_tag;
         logic        el1_eq;
         logic        el2_eq;
         logic        tag_eq;
         logic [3:0]  halfword_select;
         ctl      = breakpoint_control_reg[i];
         val      = breakpoint_value_reg[i];
         want_tag = effective_tag(val[`BVR_TAG_HI:`BVR_TAG_LO], i_pe.tag_width_select,
                                  i_pe.el2_is_narrow);
         el1_eq   = (val[31:0] == i_pe.el1_context_tag_reg);
         el2_eq   = (val[63:32] == i_pe.hyp_context_tag_reg);
         tag_eq   = (want_tag == cur_tag);
         halfword_select      = `ONLY_WIDE_STATE ? `BAS_ALL_ONES : ctl[`BAS_HI:`BAS_LO];
         ctx_hit[i] = 1'h0;
         unique case (base_type(ctl))
            3'h1: ctx_hit[i] = i_pe.host_mode ? (val[31:0] == i_pe.hyp_context_tag_reg) : el1_eq;
            3'h3: ctx_hit[i] = el1_eq;
            3'h4: ctx_hit[i] = tag_eq;
            3'h5: ctx_hit[i] = tag_eq && el1_eq;
            3'h6: ctx_hit[i] = el2_eq;
            3'h7: ctx_hit[i] = el1_eq && el2_eq;
            default: ctx_hit[i] = 1'h0;
         endcase
         ctx_hit[i] = ctx_hit[i] && ctl[`ENABLE_BIT] && i_pe.pc_valid;
         // Low halfword matches select 0011 or 1111, high halfword only select 1100
         addr_hit[i] = ctl[`ENABLE_BIT] && i_pe.pc_valid && (base_type(ctl) == 3'h0)
                    && (i_pe.pc[`BVR_VA_HI:`BVR_VA_LO] == val[`BVR_VA_HI:`BVR_VA_LO])
                    && (i_pe.pc[1] ? (halfword_select == `BAS_HIGH_HALF) : (halfword_select == `BAS_LOW_HALF || halfword_select == `BAS_ALL_ONES));
      end
   end

   // Linked partners must themselves be linked context types
   always_comb begin
      for (int i = 0; i < `BP_COUNT; i++) begin
         logic [31:0] ctl;
         logic [31:0] peer;
         ctl  = breakpoint_control_reg[i];
         peer = breakpoint_control_reg[ctl[`LBN_HI:`LBN_LO]];
         next_hit[i] = 1'h0;
         if (ctl[`ENABLE_BIT] && state_allows(ctl, i_pe.el, i_pe.secure)) begin
            if (base_type(ctl) == 3'h0) begin
               if (ctl[`BT_LO]) begin
                  next_hit[i] = addr_hit[i] && ctx_hit[ctl[`LBN_HI:`LBN_LO]] && peer[`BT_LO]
                             && is_context_type(base_type(peer));
               end else begin
                  next_hit[i] = addr_hit[i];
               end
            end else if (!ctl[`BT_LO]) begin
               // Linked context types only serve as partners
               next_hit[i] = ctx_hit[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs

   always_ff @(posedge i_clock) begin
      if (!i_rst_n || !i_warm_rst_n) begin
         o_break_hit   <= '0;
         o_debug_event <= 1'h0;
      end else begin
         o_break_hit   <= next_hit;
         o_debug_event <= |next_hit;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_walk_base         <= 48'h000000000000;
         o_guest_machine_tag <= 16'h0000;
      end else begin
         o_walk_base         <= stage2_table_base_reg[`BASE_HI:0] & align_mask;
         o_guest_machine_tag <= cur_tag;
      end
   end

endmodule : breakpoint_control_match

// file: verification/breakpoint_control_match_props.sv
// Port assertions for the breakpoint control and match block
module breakpoint_control_match_props (
   input wire logic                         i_clock,
   input wire logic                         i_rst_n,
   input wire logic                         i_warm_rst_n,
   input wire bp_match_pkg::sysreg_req_type i_sysreg_req,
   input wire bp_match_pkg::pe_state_type   i_pe,
   input wire bp_match_pkg::sysreg_rsp_type o_sysreg_rsp,
   input wire logic [15:0]                  o_break_hit,
   input wire logic                         o_debug_event,
   input wire logic [47:0]                  o_walk_base,
   input wire logic [15:0]                  o_guest_machine_tag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   logic req;
   logic s2_sel;
   ////////////////////////////////////////////////////////////////
   // Warm reset wipes a pending answer, so requests under it are left out
   assign req    = i_sysreg_req.valid && i_warm_rst_n;
   assign s2_sel = req && (i_sysreg_req.op2 & 3'h5) == 3'h0
                   && {i_sysreg_req.op0, i_sysreg_req.op1, i_sysreg_req.crn, i_sysreg_req.crm} == 13'h1c21;
   ////////////////////////////////////////////////////////////////
   rsp_follows_a: assert property (req |=> o_sysreg_rsp.valid) else $error("no answer");
   rsp_pulse_a: assert property (!req |=> !o_sysreg_rsp.valid) else $error("stray answer");
   s2_refuse_a: assert property (s2_sel && i_sysreg_req.el < 2'h2 |=> o_sysreg_rsp.undef && o_sysreg_rsp.rdata == 64'h0)
      else $error("low level reached stage-2");
   s2_accept_a: assert property (s2_sel && i_sysreg_req.el >= 2'h2 |=> !o_sysreg_rsp.undef) else $error("refused");
   unmapped_a: assert property (req && i_sysreg_req.op0 == 2'h0 |=> o_sysreg_rsp.undef) else $error("unmapped ok");
   event_or_a: assert property (o_debug_event == |o_break_hit) else $error("event not hit or");
   no_fetch_a: assert property (!i_pe.pc_valid |=> o_break_hit == 16'h0) else $error("hit without fetch");
   warm_clear_a: assert property (!i_warm_rst_n |=> !o_debug_event && !o_sysreg_rsp.valid) else $error("warm");
   tag_upper_a: assert property (!(i_pe.tag_width_select && !i_pe.el2_is_narrow) |=> o_guest_machine_tag[15:8] == 8'h0)
      else $error("upper tag used");
   walk_align_a: assert property ($past(i_rst_n) |-> (o_walk_base & ((48'h1 << $past(i_pe.base_align_bit)) - 48'h1)) == 48'h0)
      else $error("low walk bits set");
   cover property (o_debug_event);
   cover property (o_break_hit[4]);
   cover property (o_sysreg_rsp.valid && o_sysreg_rsp.undef);
endmodule : breakpoint_control_match_props

bind breakpoint_control_match breakpoint_control_match_props u_breakpoint_control_match_props (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_warm_rst_n(i_warm_rst_n), .i_sysreg_req(i_sysreg_req), .i_pe(i_pe),
   .o_sysreg_rsp(o_sysreg_rsp), .o_break_hit(o_break_hit), .o_debug_event(o_debug_event),
   .o_walk_base(o_walk_base), .o_guest_machine_tag(o_guest_machine_tag));

// file: verification/core_side_model.sv
// Core-side model: issues system register accesses and fetch addresses
module core_side_model (
   input  wire logic                         i_clock,
   input  wire bp_match_pkg::sysreg_rsp_type i_rsp,
   input  wire logic [15:0]                  i_hit,
   input  wire bp_match_pkg::pe_state_type   i_cfg,
   output bp_match_pkg::sysreg_req_type      o_req,
   output bp_match_pkg::pe_state_type        o_pe,
   output logic                              o_timeout
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        pc_valid = 1'b0;
   logic [48:0] pc       = 49'h0;
   initial begin
      o_req     = '0;
      o_timeout = 1'b0;
   end
   always_comb begin
      o_pe          = i_cfg;
      o_pe.pc_valid = pc_valid;
      o_pe.pc       = pc;
   end
   ////////////////////////////////////////////////////////////////
   // Callers issue listed encodings and type codes, plus one unmapped op0 2'h0 read
   task automatic access(input logic wr, input logic [1:0] op0, input logic [2:0] op1, input logic [3:0] crn,
                         input logic [3:0] crm, input logic [2:0] op2, input logic [1:0] el, input logic [63:0] wd,
                         output logic undef, output logic [63:0] rd);
      @(negedge i_clock);
      o_req = '{1'b1, wr, op0, op1, crn, crm, op2, el, wd};
      @(negedge i_clock);
      // Released data is inverted so stale values cannot pass
      o_req.valid = 1'b0;
      o_req.wdata = ~wd;
      o_timeout   = (i_rsp.valid !== 1'b1);
      undef       = i_rsp.undef;
      rd          = i_rsp.rdata;
   endtask : access
   task automatic fetch(input logic [48:0] addr, output logic [15:0] hit);
      @(negedge i_clock);
      pc_valid = 1'b1;
      pc       = addr;
      @(negedge i_clock);
      hit      = i_hit;
      pc_valid = 1'b0;
      pc       = ~addr;
   endtask : fetch
endmodule : core_side_model

// file: verification/breakpoint_control_match_tb.sv
// Self-checking bench for the breakpoint control and match block
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end

module breakpoint_control_match_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                         i_clock;
   logic                         i_rst_n;
   logic                         i_warm_rst_n;
   bp_match_pkg::sysreg_req_type req;
   bp_match_pkg::pe_state_type   pe;
   bp_match_pkg::pe_state_type   cfg;
   bp_match_pkg::sysreg_rsp_type rsp;
   logic [15:0]                  hit;
   logic                         event_out;
   logic [47:0]                  walk_base;
   logic [15:0]                  guest_tag;
   logic                         timeout;
   logic                         undef;
   logic [63:0]                  rd;
   logic [15:0]                  got;
   int                           fail_count = 0;
   int                           total_checks = 0;

   breakpoint_control_match u_breakpoint_control_match (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_warm_rst_n(i_warm_rst_n), .i_sysreg_req(req), .i_pe(pe), .o_sysreg_rsp(rsp), .o_break_hit(hit),
      .o_debug_event(event_out), .o_walk_base(walk_base), .o_guest_machine_tag(guest_tag));
   core_side_model u_core_side_model (.i_clock(i_clock), .i_rsp(rsp), .i_hit(hit), .i_cfg(cfg), .o_req(req),
      .o_pe(pe), .o_timeout(timeout));
   ////////////////////////////////////////////////////////////////
   task automatic dbg(input logic wr, input logic [3:0] n, input logic [2:0] op2, input logic [63:0] wd);
      u_core_side_model.access(wr, 2'h2, 3'h0, 4'h0, n, op2, 2'h1, wd, undef, rd);
   endtask : dbg
   task automatic s2(input logic wr, input logic [2:0] op2, input logic [1:0] el, input logic [63:0] wd);
      u_core_side_model.access(wr, 2'h3, 3'h4, 4'h2, 4'h1, op2, el, wd, undef, rd);
   endtask : s2
   task automatic set_bp(input logic [3:0] n, input logic [31:0] ctl, input logic [63:0] val);
      dbg(1'b1, n, 3'h5, {32'h0, ctl});
      dbg(1'b1, n, 3'h4, val);
   endtask : set_bp
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////
   task automatic s_refuse;
      s2(1'b1, 3'h0, 2'h1, 64'hffff);
      `CHK({undef, rd}, {1'b1, 64'h0})
      s2(1'b0, 3'h0, 2'h2, 64'h0);
      `CHK({undef, rd}, 65'h0)
      s2(1'b1, 3'h2, 2'h3, 64'h1234);
      `CHK(undef, 1'b0)
      u_core_side_model.access(1'b0, 2'h2, 3'h0, 4'h0, 4'h0, 3'h5, 2'h0, 64'h0, undef, rd);
      `CHK(undef, 1'b1)
      u_core_side_model.access(1'b0, 2'h0, 3'h0, 4'h0, 4'h0, 3'h0, 2'h3, 64'h0, undef, rd);
      `CHK(undef, 1'b1)
   endtask : s_refuse
   task automatic s_fields;
      dbg(1'b1, 4'h2, 3'h5, 64'hffff_ffff_ff0f_ffff);
      dbg(1'b0, 4'h2, 3'h5, 64'h0);
      `CHK(rd, 64'h000f_e1e7)
      dbg(1'b1, 4'h2, 3'h5, 64'h0025_0001);
      dbg(1'b0, 4'h2, 3'h5, 64'h0);
      `CHK(rd, 64'h0025_01e1)
   endtask : s_fields
   task automatic s_warm;
      dbg(1'b1, 4'h1, 3'h5, 64'h7);
      i_warm_rst_n = 1'b0;
      repeat (2) @(negedge i_clock);
      i_warm_rst_n = 1'b1;
      dbg(1'b0, 4'h1, 3'h5, 64'h0);
      `CHK(rd, 64'h7)
   endtask : s_warm
   task automatic s_base;
      s2(1'b1, 3'h0, 2'h2, 64'habcd_0000_1234_5fff);
      s2(1'b0, 3'h0, 2'h3, 64'h0);
      `CHK(rd, 64'habcd_0000_1234_5fff)
      `CHK(walk_base, 48'h0000_1234_5000)
      `CHK(guest_tag, 16'h00cd)
      cfg.tag_width_select = 1'b1;
      @(negedge i_clock);
      `CHK(guest_tag, 16'habcd)
      cfg.el2_is_narrow = 1'b1;
      @(negedge i_clock);
      `CHK(guest_tag, 16'h00cd)
      cfg.el2_is_narrow    = 1'b0;
      cfg.tag_width_select = 1'b0;
   endtask : s_base
   task automatic s_addr;
      logic [3:0] sel [7] = '{4'h3, 4'h3, 4'hc, 4'hc, 4'hf, 4'hf, 4'hf};
      logic [6:0] half    = 7'b0100110;
      logic [6:0] exp     = 7'b0010101;
      for (int i = 0; i < 7; i++) begin
         set_bp(4'h0, {23'h0, sel[i], (i < 6) ? 5'h07 : 5'h06}, 64'h1234_5678);
         u_core_side_model.fetch({47'h0_048d_159e, half[i], 1'b0}, got);
         `CHK(got, {15'h0, exp[i]})
      end
      set_bp(4'h0, 32'h0000_01e7, 64'h1234_5678);
      u_core_side_model.fetch(49'h1234_567c, got);
      `CHK(got, 16'h0)
      dbg(1'b1, 4'h0, 3'h5, 64'h0);
   endtask : s_addr
   task automatic s_ctx;
      logic [3:0]  code [8] = '{4'h2, 4'h6, 4'h8, 4'ha, 4'hc, 4'he, 4'ha, 4'he};
      logic [63:0] val  [8] = '{64'h1111_2222, 64'h1111_2222, 64'h00cd_0000_0000, 64'h00cd_1111_2222,
                                64'h3333_4444_0000_0000, 64'h3333_4444_1111_2222, 64'h00cd_1111_2223,
                                64'h3334_4444_1111_2222};
      for (int i = 0; i < 8; i++) begin
         cfg.host_mode = (i == 1);
         set_bp(4'h3, {8'h0, code[i], 15'h0, 5'h07}, val[i]);
         u_core_side_model.fetch(49'h100, got);
         `CHK(got, {12'h0, i < 6, 3'h0})
      end
      cfg.host_mode = 1'b0;
   endtask : s_ctx
   task automatic s_linked;
      set_bp(4'h5, 32'h0070_0007, 64'h1111_2222);
      set_bp(4'h4, 32'h0015_01e7, 64'h4000);
      u_core_side_model.fetch(49'h4000, got);
      `CHK(got, 16'h0010)
      `CHK(event_out, 1'b1)
      cfg.el1_context_tag_reg = 32'h0;
      u_core_side_model.fetch(49'h4000, got);
      `CHK(got, 16'h0)
      cfg.el1_context_tag_reg = 32'h1111_2222;
      set_bp(4'h4, 32'h0016_01e7, 64'h4000);
      u_core_side_model.fetch(49'h4000, got);
      `CHK(got, 16'h0)
      set_bp(4'h4, 32'h0015_01e6, 64'h4000);
      u_core_side_model.fetch(49'h4000, got);
      `CHK(got, 16'h0)
   endtask : s_linked
   ////////////////////////////////////////////////////////////////
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      if (timeout === 1'b1) begin
         fail_count++;
         $display("[ERR] %0t register answer missing", $time);
         end_sim();
      end
   end
   initial begin
      i_rst_n                 = 1'b0;
      i_warm_rst_n            = 1'b1;
      cfg                     = '0;
      cfg.el                  = 2'h1;
      cfg.base_align_bit      = 6'h0c;
      cfg.el1_context_tag_reg = 32'h1111_2222;
      cfg.hyp_context_tag_reg = 32'h3333_4444;
      repeat (20) @(negedge i_clock);
      `CHK({hit, event_out, walk_base, guest_tag}, 81'h0)
      i_rst_n = 1'b1;
      s_refuse();
      s_fields();
      s_warm();
      s_base();
      s_addr();
      s_ctx();
      s_linked();
      end_sim();
   end
endmodule : breakpoint_control_match_tb
